/* File: hw/exposure_ctrl_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef EXPOSURE_CTRL_REGS_SVH
`define EXPOSURE_CTRL_REGS_SVH

// Register byte offsets
`define REG_CONTROL       12'h000
`define REG_SHUTTER       12'h004
`define REG_STATUS        12'h008
`define REG_READOUT       12'h00c

// Control register fields
`define CTL_ENABLE_BIT    0
`define CTL_POL_BIT       1
`define CTL_MODE_BIT      2
`define CTL_PORT_LSB      3
`define CTL_PORT_MSB      4
`define CTL_SINGLE_BIT    5
`define CTL_REPEAT_BIT    6

// Reset values
`define CONTROL_RESET     7'h00
`define SHUTTER_RESET     12'h001
`define SHUTTER_MIN       12'h001
`define READOUT_RESET     16'h0100

// Shutter time base: 20 us at 5 ns per cycle
`define CLK_PERIOD_NS     5
`define TIME_BASE_NS      20000
`define TIME_BASE_CYCLES  (`TIME_BASE_NS / `CLK_PERIOD_NS)
`define TIME_BASE_LAST    12'hf9f

`endif

/* File: hw/exposure_ctrl_pkg.sv */
// Types shared by the exposure control design
`default_nettype none
package exposure_ctrl_pkg;
    typedef enum logic [1:0]
    {
        st_idle    = 2'b00,
        st_expose  = 2'b01,
        st_readout = 2'b10
    } state_type;

    typedef struct packed
    {
        logic       repeat_capture_arm;
        logic       single_capture_arm;
        logic [1:0] trigger_port_select;
        logic       exposure_mode_select;
        logic       trigger_edge_polarity;
        logic       trigger_acceptance_enable;
    } control_type;

    typedef struct packed
    {
        logic       trigger_ready_out;
        logic       exposing;
        logic       reading_out;
        logic       frame_done;
    } status_type;
endpackage : exposure_ctrl_pkg
`default_nettype wire

/* File: hw/trigger_sync.sv */
// Input synchroniser, port selection and edge detection for the trigger
`default_nettype none
module trigger_sync
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Trigger pins and selection
    input  wire logic [3:0] external_trigger_input,
    input  wire logic [1:0] trigger_port_select,
    input  wire logic       trigger_edge_polarity,
    // Conditioned outputs
    output logic            active_level,
    output logic            active_edge,
    output logic            release_edge
);
    logic [3:0] meta;
    logic [3:0] sync;
    logic       prev;
    logic       next_prev;
    logic       sel;

    // Two stages per pin; only the second stage is read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= 4'h0;
            sync <= 4'h0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= external_trigger_input;
            sync <= meta;
            prev <= next_prev;
        end
    end

    // Port mux after the synchroniser; switching to a port at another level shows as an edge
    always_comb
    begin
        sel       = sync[trigger_port_select]; // RQ1 RQ20
        next_prev = sel;
    end

    // Polarity folds into the level; falling polarity inverts the pin
    assign active_level = trigger_edge_polarity ? sel : ~sel; // RQ4
    assign active_edge  = trigger_edge_polarity ? (sel & ~prev)
                                                : (~sel & prev); // RQ4
    assign release_edge = trigger_edge_polarity ? (~sel & prev)
                                                : (sel & ~prev);
endmodule : trigger_sync
`default_nettype wire

/* File: hw/exposure_ctrl.sv */
// Exposure control from an external trigger with an APB register file
//
// What this block and its trigger source must do
// RQ1: Trigger taken from one of four inputs
// RQ2: Input 0 is the default trigger port
// RQ3: Trigger acted on only when enabled
// RQ4: Polarity picks rising or falling active edge
// RQ5: Source holds active level at least 1 us
// RQ6: One capture per accepted active edge
// RQ7: Source keeps below maximum frame rate
// RQ8: Mode 0 programmable, mode 1 level
// RQ9: Programmable exposure lasts shutter time exactly
// RQ10: Level mode exposes until opposite edge
// RQ11: Level mode exposure never below shutter time
// RQ12: Single arm accepts exactly one edge
// RQ13: Single arm self-clears after image transfer
// RQ14: Repeat arm accepts every edge while set
// RQ15: Source waits for trigger ready high
// RQ16: Readout follows the end of exposure
// RQ17: Ready high when safe, low at capture
// RQ18: Edges ignored while ready is low
// RQ19: Exposure is shutter times time base
// RQ20: Trigger synchronised; unarmed edges ignored
// RQ21: No new exposure during an exposure
`default_nettype none
`include "exposure_ctrl_regs.svh"
module exposure_ctrl
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Trigger pins
    input  wire logic [3:0]  external_trigger_input,
    output logic             trigger_ready_out,
    // Sensor side
    output logic             exposure_active,
    output logic             readout_active,
    output logic             frame_transferred
);
    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    exposure_ctrl_pkg::control_type control;
    exposure_ctrl_pkg::control_type next_control;
    exposure_ctrl_pkg::state_type   state;
    exposure_ctrl_pkg::state_type   next_state;
    exposure_ctrl_pkg::status_type  status;
    logic [11:0] shutter;
    logic [11:0] next_shutter;
    logic [15:0] readout_len;
    logic [15:0] next_readout_len;
    logic [11:0] base_cnt;
    logic [11:0] next_base_cnt;
    logic [11:0] units;
    logic [11:0] next_units;
    logic [15:0] ro_cnt;
    logic [15:0] next_ro_cnt;
    logic        min_done;
    logic        next_min_done;
    logic        held;
    logic        next_held;
    logic        done;
    logic        next_done;
    logic [31:0] next_prdata;
    logic        level;
    logic        edge_on;
    logic        edge_off;
    logic        accept;
    logic        wr;
    logic        rd;
    logic        tick;
    logic        last_unit;

    trigger_sync u_sync
    (
        .pclk                   (pclk),
        .presetn                (presetn),
        .external_trigger_input (external_trigger_input),
        .trigger_port_select    (control.trigger_port_select),
        .trigger_edge_polarity  (control.trigger_edge_polarity),
        .active_level           (level),
        .active_edge            (edge_on),
        .release_edge           (edge_off)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Zero wait states: every access completes in its access phase
    assign pready  = 1'b1;
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & ~penable & ~pwrite;
    assign pslverr = psel & penable & (paddr != `REG_CONTROL)
                   & (paddr != `REG_SHUTTER) & (paddr != `REG_STATUS)
                   & (paddr != `REG_READOUT);

    // Armed and ready; unarmed or busy edges are simply dropped
    assign trigger_ready_out = (state == exposure_ctrl_pkg::st_idle)
                             & control.trigger_acceptance_enable
                             & (control.single_capture_arm
                                | control.repeat_capture_arm); // RQ17
    assign accept = edge_on & trigger_ready_out; // RQ3 RQ18 RQ20 RQ21

    // Time base divider gives one pulse each shutter unit
    assign tick      = (base_cnt == `TIME_BASE_LAST);
    assign last_unit = tick & (units == shutter); // RQ19

    // ------------------------------------------------------------------
    // Register file next values
    // ------------------------------------------------------------------
    always_comb
    begin
        next_control     = control;
        next_shutter     = shutter;
        next_readout_len = readout_len;
        next_prdata      = prdata;
        if (wr && paddr == `REG_CONTROL)
        begin
            next_control = exposure_ctrl_pkg::control_type'(pwdata[6:0]);
        end
        if (wr && paddr == `REG_SHUTTER)
        begin
            // Zero is outside the legal range, so it is lifted to one
            next_shutter = (pwdata[11:0] == 12'h000) ? `SHUTTER_MIN
                                                     : pwdata[11:0]; // RQ19
        end
        if (wr && paddr == `REG_READOUT)
        begin
            next_readout_len = (pwdata[15:0] == 16'h0000) ? 16'h0001
                                                          : pwdata[15:0];
        end
        // Single arm drops once the frame has gone to the processor
        if (state == exposure_ctrl_pkg::st_readout && ro_cnt == 16'h0001
            && control.single_capture_arm)
        begin
            next_control.single_capture_arm = 1'b0; // RQ13
        end
        if (rd)
        begin
            unique case (paddr)
                `REG_CONTROL: next_prdata = {25'h0000000, control};
                `REG_SHUTTER: next_prdata = {20'h00000, shutter};
                `REG_STATUS:  next_prdata = {28'h0000000, status};
                `REG_READOUT: next_prdata = {16'h0000, readout_len};
                default:      next_prdata = 32'h00000000;
            endcase
        end
    end

    always_comb
    begin
        status = '{trigger_ready_out: trigger_ready_out,
                   exposing:    state == exposure_ctrl_pkg::st_expose,
                   reading_out: state == exposure_ctrl_pkg::st_readout,
                   frame_done:  done};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control     <= exposure_ctrl_pkg::control_type'(`CONTROL_RESET); // RQ2
            shutter     <= `SHUTTER_RESET;
            readout_len <= `READOUT_RESET;
            prdata      <= 32'h00000000;
        end
        else
        begin
            control     <= next_control;
            shutter     <= next_shutter;
            readout_len <= next_readout_len;
            prdata      <= next_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Exposure and readout sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state    = state;
        next_base_cnt = base_cnt;
        next_units    = units;
        next_ro_cnt   = ro_cnt;
        next_min_done = min_done;
        next_held     = held;
        next_done     = done;
        unique case (state)
            exposure_ctrl_pkg::st_idle:
            begin
                next_done = 1'b0;
                if (accept)
                begin
                    // One capture per accepted edge
                    next_state    = exposure_ctrl_pkg::st_expose; // RQ6 RQ12 RQ14
                    next_base_cnt = 12'h000;
                    next_units    = 12'h001;
                    next_min_done = 1'b0;
                    next_held     = 1'b1;
                end
            end
            exposure_ctrl_pkg::st_expose:
            begin
                next_base_cnt = tick ? 12'h000 : base_cnt + 12'h001;
                if (tick && !last_unit && !min_done)
                begin
                    next_units = units + 12'h001;
                end
                if (last_unit)
                begin
                    next_min_done = 1'b1;
                end
                if (edge_off || !level)
                begin
                    next_held = 1'b0; // RQ10
                end
                // Programmable ignores the pin; level waits for release too
                if (control.exposure_mode_select == 1'b0 && last_unit)
                begin
                    next_state = exposure_ctrl_pkg::st_readout; // RQ8 RQ9
                end
                else if (control.exposure_mode_select == 1'b1
                         && (min_done || last_unit)
                         && (!held || edge_off || !level))
                begin
                    next_state = exposure_ctrl_pkg::st_readout; // RQ10 RQ11
                end
                if (next_state == exposure_ctrl_pkg::st_readout)
                begin
                    next_ro_cnt = readout_len; // RQ16
                end
            end
            exposure_ctrl_pkg::st_readout:
            begin
                next_ro_cnt = ro_cnt - 16'h0001;
                if (ro_cnt == 16'h0001)
                begin
                    next_state = exposure_ctrl_pkg::st_idle; // RQ16
                    next_done  = 1'b1;
                end
            end
            default:
            begin
                next_state = exposure_ctrl_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state    <= exposure_ctrl_pkg::st_idle;
            base_cnt <= 12'h000;
            units    <= 12'h001;
            ro_cnt   <= 16'h0000;
            min_done <= 1'b0;
            held     <= 1'b0;
            done     <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            base_cnt <= next_base_cnt;
            units    <= next_units;
            ro_cnt   <= next_ro_cnt;
            min_done <= next_min_done;
            held     <= next_held;
            done     <= next_done;
        end
    end

    assign exposure_active   = (state == exposure_ctrl_pkg::st_expose);
    assign readout_active    = (state == exposure_ctrl_pkg::st_readout);
    assign frame_transferred = done;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_accept;
        accept;
    endsequence

    sequence s_expose_start;
        ##1 exposure_active && !trigger_ready_out;
    endsequence

    a_edge_starts: assert property (@(posedge pclk) disable iff (!presetn)
        s_accept |-> s_expose_start) // RQ6
        else $error("accepted edge did not start exposure");
    a_ignore_busy: assert property (@(posedge pclk) disable iff (!presetn)
        (edge_on && !trigger_ready_out && !exposure_active)
        |=> !exposure_active) // RQ18
        else $error("edge taken while not ready");
    a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !control.trigger_acceptance_enable |-> !trigger_ready_out) // RQ3
        else $error("ready while trigger disabled");
    a_arm_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (!control.single_capture_arm && !control.repeat_capture_arm)
        |-> !trigger_ready_out) // RQ20
        else $error("ready while unarmed");
    a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
        exposure_active |-> !trigger_ready_out) // RQ21
        else $error("ready during exposure");
    a_prog_length: assert property (@(posedge pclk) disable iff (!presetn)
        (exposure_active && !control.exposure_mode_select && !last_unit)
        |=> exposure_active) // RQ9
        else $error("programmable exposure ended early");
    a_level_min: assert property (@(posedge pclk) disable iff (!presetn)
        (exposure_active && !min_done && !last_unit) |=> exposure_active) // RQ11
        else $error("exposure shorter than minimum");
    a_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (exposure_active && control.exposure_mode_select && held && level
         && !edge_off) |=> exposure_active) // RQ10
        else $error("level exposure ended while held");
    a_readout_next: assert property (@(posedge pclk) disable iff (!presetn)
        (exposure_active && next_state == exposure_ctrl_pkg::st_readout)
        |=> readout_active) // RQ16
        else $error("readout did not follow exposure");
    a_single_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (readout_active && ro_cnt == 16'h0001 && !wr)
        |=> !control.single_capture_arm) // RQ13
        else $error("single arm not cleared after transfer");
endmodule : exposure_ctrl
`default_nettype wire

/* File: dv/trigger_source_model.sv */
// Behavioural external trigger source that paces itself on trigger ready
`default_nettype none
module trigger_source_model
(
    // Clock
    input  wire logic       pclk,
    // Ready from the camera
    input  wire logic       trigger_ready_out,
    // Trigger pins
    output logic      [3:0] external_trigger_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------
    // Pin drive
    // --------------------
    localparam int min_hold = 200; // 1 us of 5 ns cycles
    logic idle_level;
    // Default polarity is falling, so the pins rest high
    initial
    begin
        idle_level = 1'b1;
        external_trigger_input = 4'hf;
    end
    // Every pin rests at the inactive level of the chosen polarity
    task automatic set_polarity(input logic rising);
        @(posedge pclk);
        idle_level = ~rising;
        external_trigger_input <= {4{~rising}};
    endtask : set_polarity
    // One active pulse; obey low skips the ready check on purpose
    task automatic pulse(input logic [1:0] port, input int hold,
                         input logic obey);
        int len;
        len = (hold < min_hold) ? min_hold : hold;
        while (obey && trigger_ready_out !== 1'b1)
        begin
            @(posedge pclk);
        end
        @(posedge pclk);
        external_trigger_input[port] <= ~idle_level;
        repeat (len) @(posedge pclk);
        external_trigger_input[port] <= idle_level;
    endtask : pulse
endmodule : trigger_source_model
`default_nettype wire

/* File: dv/external_trigger_exposure_ctrl_test.sv */
// Self-checking bench for the external trigger exposure control
`default_nettype none
`define CHECK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("Error %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module external_trigger_exposure_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        ready, expo, rdo, frame, rerr, exp_prev, ready_bad;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pins;
    int          fail_count, samples_checked, cycles, n0;
    int          exp_run, exp_len, rd_run, rd_len, exp_count, frame_count;

    exposure_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_trigger_input(pins),
        .trigger_ready_out(ready), .exposure_active(expo),
        .readout_active(rdo), .frame_transferred(frame));
    trigger_source_model src (.pclk(pclk), .trigger_ready_out(ready),
        .external_trigger_input(pins));

    // 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // --------------------
    // Monitor and timeout
    // --------------------
    // Lengths are measured in cycles so they compare to the time base
    always @(posedge pclk)
    begin
        cycles++;
        if (expo === 1'b1)
            exp_run++;
        else if (exp_run != 0)
        begin
            exp_len = exp_run;
            exp_run = 0;
        end
        if (rdo === 1'b1)
            rd_run++;
        else if (rd_run != 0)
        begin
            rd_len = rd_run;
            rd_run = 0;
        end
        if (expo === 1'b1 && exp_prev !== 1'b1)
            exp_count++;
        exp_prev = expo;
        if (frame === 1'b1)
            frame_count++;
        if (ready === 1'b1 && (expo === 1'b1 || rdo === 1'b1))
            ready_bad = 1'b1;
        // Ceiling well above the summed scenario lengths
        if (cycles == 60000)
        begin
            fail_count++;
            test_done();
        end
    end
    // --------------------
    // Shared tasks
    // --------------------
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_check(input logic [11:0] a, input logic [31:0] e,
                            input string what);
        apb(1'b0, a, 32'h0);
        `CHECK(what, e, rdata)
    endtask : rd_check
    // Give detection time, then wait out exposure and readout
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (8) @(posedge pclk);
        while ((expo !== 1'b0 || rdo !== 1'b0) && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        // A capture that never ends is a failure, not a silent return
        if (n >= 20000)
            fail_count++;
        repeat (4) @(posedge pclk);
    endtask : wait_idle
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset();
        rd_check(12'h000, 32'h0, "control");
        rd_check(12'h004, 32'h1, "shutter");
        rd_check(12'h00c, 32'h100, "readout");
        rd_check(12'h008, 32'h0, "status");
        apb(1'b1, 12'h004, 32'h0);
        rd_check(12'h004, 32'h1, "shutter floor");
        apb(1'b0, 12'h010, 32'h0);
        `CHECK("unmapped error", 1'b1, rerr)
        `CHECK("unmapped data", 32'h0, rdata)
        $display("test reset done");
    endtask : t_reset
    // Second pulse is forced into the running exposure
    task automatic t_prog();
        apb(1'b1, 12'h00c, 32'h10);
        src.set_polarity(1'b1);
        apb(1'b1, 12'h000, 32'h43);
        n0 = exp_count;
        src.pulse(2'h0, 300, 1'b1);
        src.pulse(2'h0, 300, 1'b0);
        wait_idle();
        `CHECK("exposures", n0 + 1, exp_count)
        `CHECK("exposure length", 4000, exp_len)
        `CHECK("readout length", 16, rd_len)
        `CHECK("frames", 1, frame_count)
        `CHECK("ready in capture", 1'b0, ready_bad)
        `CHECK("ready after", 1'b1, ready)
        $display("test prog done");
    endtask : t_prog
    task automatic t_level();
        // Retarget first: moving the pins under the old armed setup
        // would be an active edge and start a stray exposure
        apb(1'b1, 12'h000, 32'h4d);
        src.set_polarity(1'b0);
        n0 = exp_count;
        src.pulse(2'h0, 300, 1'b0);
        repeat (20) @(posedge pclk);
        `CHECK("other port", n0, exp_count)
        for (int p = 1; p < 4; p++)
        begin
            apb(1'b1, 12'h000, 32'h45 | (32'(p) << 3));
            src.pulse(2'(p), (p == 2) ? 1000 : 6000, 1'b1);
            wait_idle();
            if (p == 2)
                `CHECK("minimum", 4000, exp_len)
            else
                `CHECK("level", 1'b1, exp_len inside {[5997:6003]})
        end
        `CHECK("level exposures", n0 + 3, exp_count)
        $display("test level done");
    endtask : t_level
    task automatic t_single();
        apb(1'b1, 12'h000, 32'h23);
        src.set_polarity(1'b1);
        apb(1'b1, 12'h004, 32'h2);
        n0 = exp_count;
        src.pulse(2'h0, 300, 1'b1);
        wait_idle();
        `CHECK("two units", 8000, exp_len)
        apb(1'b1, 12'h004, 32'h1);
        rd_check(12'h000, 32'h3, "arm cleared");
        `CHECK("ready unarmed", 1'b0, ready)
        src.pulse(2'h0, 300, 1'b0);
        repeat (20) @(posedge pclk);
        `CHECK("single count", n0 + 1, exp_count)
        $display("test single done");
    endtask : t_single
    task automatic t_gates();
        n0 = exp_count;
        apb(1'b1, 12'h000, 32'h42);
        @(posedge pclk);
        `CHECK("ready disabled", 1'b0, ready)
        src.pulse(2'h0, 300, 1'b0);
        apb(1'b1, 12'h000, 32'h03);
        src.pulse(2'h0, 300, 1'b0);
        repeat (20) @(posedge pclk);
        `CHECK("gated count", n0, exp_count)
        apb(1'b1, 12'h000, 32'h43);
        src.pulse(2'h0, 300, 1'b1);
        src.pulse(2'h0, 300, 1'b1);
        wait_idle();
        `CHECK("repeat count", n0 + 2, exp_count)
        apb(1'b1, 12'h000, 32'h03);
        src.pulse(2'h0, 300, 1'b0);
        repeat (20) @(posedge pclk);
        `CHECK("disarmed count", n0 + 2, exp_count)
        $display("test gates done");
    endtask : t_gates
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, presetn, exp_prev, ready_bad} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_prog();
        t_level();
        t_single();
        t_gates();
        test_done();
    end
endmodule : external_trigger_exposure_ctrl_test
`default_nettype wire
